// *** evp_egress_top.sv ***
// Egress tag policy and port 0 queue pacing with an AXI4-Lite slave.
// Assumes frames and byte strobes are synchronous to aclk.
module evp_egress_top
    import evp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_valid,
    input wire evp_pkg::evp_frame_t frame_in,
    output logic decision_valid,
    output evp_pkg::evp_decision_t decision_out,
    input wire logic pacing_enable,
    input wire logic [3:0] queue_byte_sent,
    output logic [3:0] queue_ready
);
    import evp_pkg::*;

    // Word match of a byte address against a register index (byte address is 4 x index)
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
        hit = (addr[15:2] == idx[13:0]);
    endfunction : hit

    // Byte-lane merge limited to the writable bits
    function automatic logic [31:0] merge_write(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb,
        input logic [31:0] mask
    );
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge_write = ((old_val & ~lanes) | (new_val & lanes)) & mask;
    endfunction : merge_write

    // Pacing debt in ns for one byte: (field + 1) * unit
    function automatic logic [DEBT_W-1:0] byte_time_ns(input logic [PACE_W-1:0] field);
        logic [DEBT_W-1:0] steps;
        steps = DEBT_W'({5'h00, field}) + DEBT_W'(1);
        byte_time_ns = DEBT_W'(steps * DEBT_W'(PACE_UNIT_NS));
    endfunction : byte_time_ns

    logic [31:0] policy_reg;
    logic [31:0] pace01_reg;
    logic [31:0] pace23_reg;
    logic [15:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic do_write;
    logic [DEBT_W-1:0] debt_reg [4];
    logic [DEBT_W-1:0] debt_next [4];
    logic [PACE_W-1:0] pace_field [4];
    logic [7:0] frame_count_reg;
    logic [31:0] status_word;
    logic [31:0] read_word;
    logic read_ok;
    evp_decision_t decision_comb;

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // Write address channel; one write outstanding at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 16'h0000;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held_reg <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel, taken in either order relative to the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held_reg <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Write response; unmapped addresses answer SLVERR and store nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (hit(aw_addr_reg, IDX_EGRESS_TAG_POLICY)) begin
                s_axi_bresp <= RESP_OKAY;
            end else if (hit(aw_addr_reg, IDX_PORT0_QUEUE01_PACING)) begin
                s_axi_bresp <= RESP_OKAY;
            end else if (hit(aw_addr_reg, IDX_PORT0_QUEUE23_PACING)) begin
                s_axi_bresp <= RESP_OKAY;
            end else if (hit(aw_addr_reg, IDX_PACING_STATUS)) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Tag policy register; all control bits reset to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            policy_reg <= POLICY_RESET;
        end else if (do_write && hit(aw_addr_reg, IDX_EGRESS_TAG_POLICY)) begin
            policy_reg <= merge_write(policy_reg, w_data_reg, w_strb_reg, POLICY_MASK);
        end
    end

    // Pacing registers for queues 0..3 of port 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pace01_reg <= PACING_RESET;
            pace23_reg <= PACING_RESET;
        end else if (do_write) begin
            if (hit(aw_addr_reg, IDX_PORT0_QUEUE01_PACING)) begin
                pace01_reg <= merge_write(pace01_reg, w_data_reg, w_strb_reg, PACING_MASK);
            end else if (hit(aw_addr_reg, IDX_PORT0_QUEUE23_PACING)) begin
                pace23_reg <= merge_write(pace23_reg, w_data_reg, w_strb_reg, PACING_MASK);
            end
        end
    end

    // Queue field extraction
    assign pace_field[0] = pace01_reg[POS_PACE_LO +: PACE_W];
    assign pace_field[1] = pace01_reg[POS_PACE_HI +: PACE_W];
    assign pace_field[2] = pace23_reg[POS_PACE_LO +: PACE_W];
    assign pace_field[3] = pace23_reg[POS_PACE_HI +: PACE_W];

    // Read-only status: pacing hold per queue and frames decided
    assign status_word = {16'h0000, frame_count_reg, 4'h0, ~queue_ready};

    // Read decode; reserved bits come back as zero
    always_comb begin
        read_word = 32'h0000_0000;
        read_ok = 1'b1;
        if (hit(s_axi_araddr, IDX_EGRESS_TAG_POLICY)) begin
            read_word = policy_reg & POLICY_MASK;
        end else if (hit(s_axi_araddr, IDX_PORT0_QUEUE01_PACING)) begin
            read_word = pace01_reg & PACING_MASK;
        end else if (hit(s_axi_araddr, IDX_PORT0_QUEUE23_PACING)) begin
            read_word = pace23_reg & PACING_MASK;
        end else if (hit(s_axi_araddr, IDX_PACING_STATUS)) begin
            read_word = status_word;
        end else begin
            read_ok = 1'b0;
        end
    end

    // Read channel: data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Tag decision logic for the offered frame
    evp_tag_decide u_decide (
        .policy(policy_reg),
        .frame(frame_in),
        .decision(decision_comb)
    );

    // Registered decision, one cycle after the frame strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            decision_valid <= 1'b0;
            decision_out <= '0;
        end else begin
            decision_valid <= frame_valid;
            if (frame_valid) begin
                decision_out <= decision_comb;
            end
        end
    end

    // Frame counter for the status register, wraps at 8 bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_count_reg <= 8'h00;
        end else if (frame_valid) begin
            frame_count_reg <= frame_count_reg + 8'h01;
        end
    end

    // Debt drains by one clock period each cycle; a sent byte reloads it.
    // Ready waits for zero debt, so pacing may run slow but never fast.
    always_comb begin
        for (int q = 0; q < 4; q++) begin
            if (!pacing_enable) begin
                debt_next[q] = '0;
            end else if (queue_byte_sent[q]) begin
                debt_next[q] = byte_time_ns(pace_field[q]);
            end else if (debt_reg[q] > DEBT_W'(CLK_PERIOD_NS)) begin
                debt_next[q] = debt_reg[q] - DEBT_W'(CLK_PERIOD_NS);
            end else begin
                debt_next[q] = '0;
            end
        end
    end

    // Pacing state and per-queue ready flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int q = 0; q < 4; q++) begin
                debt_reg[q] <= '0;
            end
            queue_ready <= 4'hf;
        end else begin
            for (int q = 0; q < 4; q++) begin
                debt_reg[q] <= debt_next[q];
                queue_ready[q] <= (debt_next[q] == '0);
            end
        end
    end

endmodule : evp_egress_top

// *** evp_pkg.sv ***
// Package for the egress VLAN tagging and port 0 queue pacing block.
// Assumes one clock domain (aclk, 40 MHz) and an AXI4-Lite register bus.
package evp_pkg;

    // Register indices as numbered; byte address is four times the index
    localparam logic [15:0] IDX_EGRESS_TAG_POLICY = 16'h1c0c;
    localparam logic [15:0] IDX_PORT0_QUEUE01_PACING = 16'h1c0d;
    localparam logic [15:0] IDX_PORT0_QUEUE23_PACING = 16'h1c0e;
    localparam logic [15:0] IDX_PACING_STATUS = 16'h1c20;
    localparam int AXI_ADDR_W = 16;

    // Writable bit masks; reserved bits read zero and ignore writes
    localparam logic [31:0] POLICY_MASK = 32'h007f_7f7f;
    localparam logic [31:0] PACING_MASK = 32'h03ff_ffff;
    localparam logic [31:0] POLICY_RESET = 32'h0000_0000;
    localparam logic [31:0] PACING_RESET = 32'h0000_0000;

    // Per-port field layout inside the tag policy register
    localparam int PORT_STRIDE = 8;
    localparam int POS_TYPE = 0;
    localparam int POS_CHG_TAG = 2;
    localparam int POS_CHG_PRI = 3;
    localparam int POS_CHG_VID = 4;
    localparam int POS_INS_TAG = 5;
    localparam int POS_VID_SEL = 6;

    // Pacing field layout: two 13-bit fields per register
    localparam int PACE_W = 13;
    localparam int POS_PACE_LO = 0;
    localparam int POS_PACE_HI = 13;

    // Time per byte is (field + 1) * PACE_UNIT_NS; debt is kept in ns
    localparam int PACE_UNIT_NS = 20;
    localparam int CLK_FREQ_MHZ = 40;
    localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
    localparam int DEBT_W = 18;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        PT_DUMB,
        PT_ACCESS,
        PT_HYBRID,
        PT_CPU
    } evp_port_type_t;

    typedef enum logic [1:0] {
        TAG_NONE,
        TAG_PRIORITY,
        TAG_REGULAR,
        TAG_SPECIAL
    } evp_tag_kind_t;

    typedef enum logic [2:0] {
        ACT_KEEP,
        ACT_STRIP,
        ACT_INSERT,
        ACT_REWRITE,
        ACT_ADD_SPECIAL
    } evp_action_t;

    // One frame offered to an egress port
    typedef struct packed {
        logic [1:0] egress_port;
        logic [1:0] source_port;
        evp_tag_kind_t tag_kind;
        logic [11:0] vid;
        logic [2:0] pri;
        logic [11:0] ingress_def_vid;
        logic [2:0] ingress_pri;
        logic [11:0] egress_def_vid;
        logic [2:0] egress_def_pri;
        logic untag_default;
        logic untag_incoming;
    } evp_frame_t;

    // Tag decision for that frame
    typedef struct packed {
        evp_action_t action;
        logic [11:0] vid;
        logic [2:0] pri;
        logic [1:0] source_port;
    } evp_decision_t;

endpackage : evp_pkg

// *** evp_tag_decide.sv ***
// Combinational tag decision for one frame leaving one port.
// Assumes the caller registers the result and supplies the 32-bit policy.
module evp_tag_decide
    import evp_pkg::*;
(
    input wire logic [31:0] policy,
    input wire evp_pkg::evp_frame_t frame,
    output evp_pkg::evp_decision_t decision
);

    logic [7:0] port_bits;
    evp_port_type_t ptype;
    logic chg_tag;
    logic chg_pri;
    logic chg_vid;
    logic ins_tag;
    logic vid_sel;
    logic [11:0] sel_vid;
    logic [2:0] sel_pri;

    // Pick the egress port's own slice of the policy register
    always_comb begin
        port_bits = policy[frame.egress_port * PORT_STRIDE +: PORT_STRIDE];
        ptype = evp_port_type_t'(port_bits[POS_TYPE +: 2]);
        chg_tag = port_bits[POS_CHG_TAG];
        chg_pri = port_bits[POS_CHG_PRI];
        chg_vid = port_bits[POS_CHG_VID];
        ins_tag = port_bits[POS_INS_TAG];
        vid_sel = port_bits[POS_VID_SEL];
        sel_vid = vid_sel ? frame.egress_def_vid : frame.ingress_def_vid;
        sel_pri = vid_sel ? frame.egress_def_pri : frame.ingress_pri;
    end

    // Action per egress type; hybrid controls are ignored outside hybrid
    always_comb begin
        decision.action = ACT_KEEP;
        decision.vid = frame.vid;
        decision.pri = frame.pri;
        decision.source_port = frame.source_port;
        case (ptype)
            PT_DUMB: begin
                if (frame.tag_kind == TAG_SPECIAL) begin
                    decision.action = ACT_STRIP;
                end
            end
            PT_ACCESS: begin
                if (frame.tag_kind != TAG_NONE) begin
                    decision.action = ACT_STRIP;
                end
            end
            PT_HYBRID: begin
                case (frame.tag_kind)
                    TAG_NONE: begin
                        if (ins_tag && !frame.untag_default) begin
                            decision.action = ACT_INSERT;
                            decision.vid = sel_vid;
                            decision.pri = sel_pri;
                        end
                    end
                    TAG_PRIORITY: begin
                        // Un-tag membership wins over any change
                        if (frame.untag_incoming) begin
                            decision.action = ACT_STRIP;
                        end else begin
                            decision.action = ACT_REWRITE;
                            decision.vid = sel_vid;
                            if (chg_pri) begin
                                decision.pri = sel_pri;
                            end
                        end
                    end
                    TAG_REGULAR: begin
                        if (frame.untag_incoming) begin
                            decision.action = ACT_STRIP;
                        end else if (chg_tag && (chg_vid || chg_pri)) begin
                            decision.action = ACT_REWRITE;
                            if (chg_vid) begin
                                decision.vid = sel_vid;
                            end
                            if (chg_pri) begin
                                decision.pri = sel_pri;
                            end
                        end
                    end
                    default: begin
                        decision.action = ACT_STRIP;
                    end
                endcase
            end
            default: begin
                decision.action = ACT_ADD_SPECIAL;
            end
        endcase
    end

endmodule : evp_tag_decide

// *** evp_props.sv ***
// Checker for the egress tag and pacing block, seeing only its top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
module evp_props
    import evp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_valid,
    input wire evp_pkg::evp_frame_t frame_in,
    input wire logic decision_valid,
    input wire evp_pkg::evp_decision_t decision_out,
    input wire logic pacing_enable,
    input wire logic [3:0] queue_ready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Write is answered two edges after both channels are taken together
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    property p_wr_resp;
        s_wr_both |-> ##2 s_wr_answer;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer missing");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed");

    // Decision comes exactly one cycle after each frame and holds between frames
    property p_dec_lat;
        frame_valid |=> decision_valid;
    endproperty
    a_dec_lat: assert property (p_dec_lat) else $error("decision late");
    property p_dec_hold;
        !frame_valid |=> !decision_valid && $stable(decision_out);
    endproperty
    a_dec_hold: assert property (p_dec_hold) else $error("stray decision");
    property p_special_src;
        decision_valid && decision_out.action == ACT_ADD_SPECIAL |->
            decision_out.source_port == $past(frame_in.source_port);
    endproperty
    a_special_src: assert property (p_special_src) else $error("wrong source");
    property p_special_gone;
        frame_valid && frame_in.tag_kind == TAG_SPECIAL |=> decision_out.action != ACT_KEEP;
    endproperty
    a_special_gone: assert property (p_special_gone) else $error("special kept");
    property p_untagged;
        frame_valid && frame_in.tag_kind == TAG_NONE |=>
            decision_out.action != ACT_STRIP && decision_out.action != ACT_REWRITE;
    endproperty
    a_untagged: assert property (p_untagged) else $error("untagged altered");
    property p_pace_off;
        !pacing_enable |=> queue_ready == 4'hf;
    endproperty
    a_pace_off: assert property (p_pace_off) else $error("queue held");
endmodule : evp_props

bind evp_egress_top evp_props evp_props_i (.*);

// *** evp_tx_partner.sv ***
// Transmit path of port 0: sends bytes from the paced queues.
// Assumes queue_ready is a registered level; go stalls or releases each queue.
module evp_tx_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] go,
    input wire logic [3:0] queue_ready,
    output logic [3:0] queue_byte_sent
);
    // A pending pulse blocks a second send, since ready reacts one edge late
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            queue_byte_sent <= 4'h0;
        end else begin
            queue_byte_sent <= go & queue_ready & ~queue_byte_sent;
        end
    end
endmodule : evp_tx_partner

// *** tb.sv ***
// Self-checking bench for the egress tag policy and queue pacing block.
// Assumes a 40 MHz aclk and register access over AXI4-Lite only.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import evp_pkg::*;

    localparam logic [15:0] A_POL = {IDX_EGRESS_TAG_POLICY[13:0], 2'b00};
    localparam logic [15:0] A_P01 = {IDX_PORT0_QUEUE01_PACING[13:0], 2'b00};
    localparam logic [15:0] A_P23 = {IDX_PORT0_QUEUE23_PACING[13:0], 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic frame_valid = 1'b0;
    evp_frame_t frame_in = '0;
    logic decision_valid;
    evp_decision_t decision_out;
    logic pacing_enable = 1'b1;
    logic [3:0] queue_byte_sent;
    logic [3:0] queue_ready;
    logic [3:0] go = 4'h0;
    int n_fail = 0;
    int tests_run = 0;

    evp_egress_top evp_egress_top_i (.*);
    evp_tx_partner evp_tx_partner_i (.aclk(aclk), .aresetn(aresetn), .go(go),
        .queue_ready(queue_ready), .queue_byte_sent(queue_byte_sent));

    // 25 ns period
    always #12.5 aclk = ~aclk;

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // Bready rises only once bvalid is seen, so a waiting answer must hold
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        cmp(s_axi_bresp, er, "bresp");
    endtask : axi_wr

    // Rready likewise follows rvalid; the data is taken at the handshake edge
    task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        cmp(s_axi_rdata, ed, "rdata");
        cmp(s_axi_rresp, er, "rresp");
    endtask : axi_rd

    // Reset values, reserved bits, byte lanes and an unmapped address
    task automatic t_regs();
        axi_rd(A_POL, 32'h0000_0000, RESP_OKAY);
        axi_rd(A_P01, 32'h0000_0000, RESP_OKAY);
        axi_rd(A_P23, 32'h0000_0000, RESP_OKAY);
        axi_wr(A_POL, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_rd(A_POL, 32'h007f_7f7f, RESP_OKAY);
        axi_wr(A_POL, 32'h0000_0000, 4'h2, RESP_OKAY);
        axi_rd(A_POL, 32'h007f_007f, RESP_OKAY);
        axi_wr(A_P01, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_rd(A_P01, 32'h03ff_ffff, RESP_OKAY);
        axi_wr(A_P23, 32'hffff_ffff, 4'hf, RESP_OKAY);
        axi_rd(A_P23, 32'h03ff_ffff, RESP_OKAY);
        axi_wr(16'h0100, 32'h1234_5678, 4'hf, RESP_SLVERR);
        axi_rd(16'h0100, 32'h0000_0000, RESP_SLVERR);
        $display("test registers finished");
    endtask : t_regs

    // One frame under one policy; vid and pri judged only when a tag is written
    task automatic frm(input logic [31:0] pol, input logic [1:0] port, input evp_tag_kind_t k,
        input logic ud, input evp_action_t ea, input logic [11:0] ev, input logic [2:0] ep);
        axi_wr(A_POL, pol, 4'hf, RESP_OKAY);
        frame_valid <= 1'b1;
        frame_in <= '{port, 2'h2, k, 12'h123, 3'h5, 12'h0a1, 3'h2, 12'h0b2, 3'h6, ud, 1'b0};
        @(posedge aclk);
        frame_valid <= 1'b0;
        @(posedge aclk);
        cmp(decision_valid, 1'b1, "decision valid");
        cmp(decision_out.action, ea, "action");
        if (ea == ACT_INSERT || ea == ACT_REWRITE) begin
            cmp(decision_out.vid, ev, "vid");
            cmp(decision_out.pri, ep, "pri");
        end
        if (ea == ACT_ADD_SPECIAL) cmp(decision_out.source_port, 2'h2, "source");
    endtask : frm

    task automatic t_frames();
        frm(32'h00, 2'd0, TAG_REGULAR, 1'b0, ACT_KEEP, 12'h0, 3'h0);
        frm(32'h00, 2'd0, TAG_SPECIAL, 1'b0, ACT_STRIP, 12'h0, 3'h0);
        frm(32'h01, 2'd0, TAG_REGULAR, 1'b0, ACT_STRIP, 12'h0, 3'h0);
        frm(32'h01, 2'd0, TAG_SPECIAL, 1'b0, ACT_STRIP, 12'h0, 3'h0);
        frm(32'h03, 2'd0, TAG_REGULAR, 1'b0, ACT_ADD_SPECIAL, 12'h0, 3'h0);
        frm(32'h22, 2'd0, TAG_NONE, 1'b0, ACT_INSERT, 12'h0a1, 3'h2);
        frm(32'h62, 2'd0, TAG_NONE, 1'b0, ACT_INSERT, 12'h0b2, 3'h6);
        frm(32'h22, 2'd0, TAG_NONE, 1'b1, ACT_KEEP, 12'h0, 3'h0);
        frm(32'h20, 2'd0, TAG_NONE, 1'b0, ACT_KEEP, 12'h0, 3'h0);
        frm(32'h12, 2'd0, TAG_REGULAR, 1'b0, ACT_KEEP, 12'h0, 3'h0);
        frm(32'h16, 2'd0, TAG_REGULAR, 1'b0, ACT_REWRITE, 12'h0a1, 3'h5);
        frm(32'h0e, 2'd0, TAG_REGULAR, 1'b0, ACT_REWRITE, 12'h123, 3'h2);
        frm(32'h02, 2'd0, TAG_PRIORITY, 1'b0, ACT_REWRITE, 12'h0a1, 3'h5);
        frm(32'h4a, 2'd0, TAG_PRIORITY, 1'b0, ACT_REWRITE, 12'h0b2, 3'h6);
        frm(32'h06, 2'd0, TAG_PRIORITY, 1'b0, ACT_REWRITE, 12'h0a1, 3'h5);
        frm(32'h2200, 2'd1, TAG_NONE, 1'b0, ACT_INSERT, 12'h0a1, 3'h2);
        frm(32'h30000, 2'd2, TAG_REGULAR, 1'b0, ACT_ADD_SPECIAL, 12'h0, 3'h0);
        frm(32'h03, 2'd2, TAG_REGULAR, 1'b0, ACT_KEEP, 12'h0, 3'h0);
        $display("test frames finished");
    endtask : t_frames

    // Count the cycles a queue stays closed after one byte
    task automatic pace_run(input int q, input int exp_low);
        int n;
        int lo;
        n = 0;
        lo = 0;
        go[q] <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (queue_ready[q] === 1'b0) begin
                lo++;
                go[q] <= 1'b0;
            end
        end while ((lo == 0 || queue_ready[q] === 1'b0) && n < 60);
        go[q] <= 1'b0;
        cmp(lo, exp_low, "closed cycles");
    endtask : pace_run

    task automatic t_pacing();
        axi_wr(A_P01, (32'd9 << 13) | 32'd4, 4'hf, RESP_OKAY);
        axi_wr(A_P23, (32'd4 << 13) | 32'd9, 4'hf, RESP_OKAY);
        pace_run(0, 5 * PACE_UNIT_NS / CLK_PERIOD_NS);
        pace_run(1, 10 * PACE_UNIT_NS / CLK_PERIOD_NS);
        pace_run(2, 10 * PACE_UNIT_NS / CLK_PERIOD_NS);
        pace_run(3, 5 * PACE_UNIT_NS / CLK_PERIOD_NS);
        pacing_enable <= 1'b0;
        go <= 4'hf;
        repeat (6) @(posedge aclk);
        cmp(queue_ready, 4'hf, "ready while off");
        go <= 4'h0;
        pacing_enable <= 1'b1;
        $display("test pacing finished");
    endtask : t_pacing

    // Main sequence after ten cycles of reset
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_frames();
        t_pacing();
        close_out();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        close_out();
    end
endmodule : tb
